// file: rtl/rupl_pkg.sv
// Shared constants for the user packet and loss tuning register slice.
package rupl_pkg;

	// ****************************************************************
	// Register offsets and reset values
	// ****************************************************************
	localparam logic [7:0] MAILBOX_ADDR = 8'hE0;
	localparam logic [7:0] LOSS_TUNE_ADDR = 8'hE1;
	localparam logic [7:0] HEADER_ADDR = 8'hE2;
	localparam logic [7:0] MAILBOX_RESET = 8'h80;
	localparam logic [7:0] LOSS_TUNE_RESET = 8'h00;
	localparam logic [7:0] HEADER_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************************************
	// Mailbox fields
	// ****************************************************************
	localparam int COMPLETE_BIT = 7;
	localparam int FAULT_HI = 6;
	localparam int FAULT_LO = 5;
	localparam int MAILER_SPARE_BIT = 4;
	localparam int ALIGN_BIT = 3;
	localparam int SCALE_SPARE_BIT = 2;
	localparam logic [7:0] MAILBOX_HOST_MASK = 8'h1F;

	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] FAULT_NO_TX = 2'h1;
	localparam logic [1:0] FAULT_BAD_HEADER = 2'h2;

	// ****************************************************************
	// Loss tuning fields
	// ****************************************************************
	localparam int RES_ON_BIT = 7;
	localparam int OFF_ON_BIT = 6;
	localparam int OFF_HI = 5;
	localparam int OFF_LO = 3;
	localparam int RES_HI = 2;
	localparam int RES_LO = 0;

	localparam logic [2:0] RES_X1 = 3'h0;
	localparam logic [2:0] RES_X2 = 3'h2;
	localparam logic [2:0] RES_X3 = 3'h3;
	localparam logic [2:0] RES_X4 = 3'h4;
	localparam logic [2:0] RES_HALF = 3'h7;

	// Received power and offset share the same step size.
	localparam int POWER_LSB_MW = 39;
	localparam int OFFSET_STEP_MW = 39;
	localparam int OFFSET_STEP_LSB = OFFSET_STEP_MW / POWER_LSB_MW;
	localparam logic [9:0] POWER_MAX = 10'h0FF;

	// ****************************************************************
	// Header decode: low two bits pick one to four payload bytes.
	// ****************************************************************
	localparam int LEN_HI = 1;
	localparam int LEN_LO = 0;
	localparam logic [7:0] HEADER_INVALID = 8'h00;

	typedef enum logic [1:0]
	{
		RUPL_IDLE = 2'b00,
		RUPL_WAIT_SLOT = 2'b01,
		RUPL_SENDING = 2'b10
	} rupl_state_e;

endpackage

// file: rtl/rupl_power_adj.sv
// Received power figure adjusted by loss factor and fixed offset.
`timescale 1ns/100ps
module rupl_power_adj
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] base_power_in,
	input wire logic [7:0] loss_term_in,
	input wire logic res_on_in,
	input wire logic off_on_in,
	input wire logic [2:0] off_code_in,
	input wire logic [2:0] res_code_in,
	output logic [7:0] power_out
);
	logic [9:0] scaled_loss;
	logic [9:0] loss_used;
	logic [9:0] offset_used;
	logic [10:0] power_sum;
	logic [9:0] loss_wide;

	// ****************************************************************
	// Loss scaling
	// ****************************************************************
	assign loss_wide = {2'h0, loss_term_in};
	// Codes without a listed factor keep the nominal resistor.
	assign scaled_loss =
		(res_code_in == rupl_pkg::RES_X2) ? (loss_wide << 1) :
		(res_code_in == rupl_pkg::RES_X3) ? (loss_wide + (loss_wide << 1)) :
		(res_code_in == rupl_pkg::RES_X4) ? (loss_wide << 2) :
		(res_code_in == rupl_pkg::RES_HALF) ? (loss_wide >> 1) :
		loss_wide;
	assign loss_used = res_on_in ? scaled_loss : loss_wide;
	assign offset_used = off_on_in ?
		10'(off_code_in * rupl_pkg::OFFSET_STEP_LSB) : 10'h000;
	// Eleven bits hold the largest sum, so saturation never sees a wrap.
	assign power_sum = 11'(base_power_in + loss_used + offset_used);

	// Saturate rather than wrap so a large tuning never reads as low power.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			power_out <= 8'h00;
		else if (power_sum > rupl_pkg::POWER_MAX)
			power_out <= rupl_pkg::POWER_MAX[7:0];
		else
			power_out <= power_sum[7:0];
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_res_off_nominal;
		!res_on_in && !off_on_in && (10'(base_power_in) +
			10'(loss_term_in) <= rupl_pkg::POWER_MAX) |=> power_out ==
			8'($past(base_power_in) + $past(loss_term_in));
	endproperty
	a_res_off_nominal: assert property (p_res_off_nominal)
		else $error("Disabled tuning changed the power figure.");

	property p_double;
		res_on_in && !off_on_in && res_code_in == rupl_pkg::RES_X2 &&
			loss_term_in < 8'h40 && base_power_in < 8'h80 |=>
			power_out == 8'($past(base_power_in) + 2 * $past(loss_term_in));
	endproperty
	a_double: assert property (p_double)
		else $error("Doubled loss factor not applied.");

	property p_offset;
		!res_on_in && off_on_in && base_power_in < 8'h80 &&
			loss_term_in < 8'h40 |=> power_out == 8'($past(base_power_in) +
			$past(loss_term_in) + $past(off_code_in));
	endproperty
	a_offset: assert property (p_offset)
		else $error("Power offset not added in steps of one code.");
endmodule

// file: rtl/rupl_regs.sv
// Register slice for user packets, alignment aid and loss tuning.
`timescale 1ns/100ps
module rupl_regs
(
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic rectified_voltage_ok_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wr_addr_in,
	input wire logic [7:0] reg_wr_data_in,
	input wire logic [7:0] reg_rd_addr_in,
	input wire logic tx_present_in,
	input wire logic comm_slot_in,
	input wire logic pkt_sent_in,
	input wire logic [7:0] base_power_in,
	input wire logic [7:0] loss_term_in,
	output logic [7:0] reg_rd_data_out,
	output logic pkt_start_out,
	output logic [7:0] pkt_header_out,
	output logic [2:0] pkt_payload_count_out,
	output logic align_cep_zero_out,
	output logic [7:0] reported_power_out
);
	logic rst_meta_reg, rst_sync_b_reg, uvlo_meta_reg, uvlo_ok_reg;
	logic [7:0] mailbox_reg;
	logic [7:0] mailbox_next;
	logic [7:0] loss_tune_reg;
	logic [7:0] header_reg;
	rupl_pkg::rupl_state_e state_reg;
	rupl_pkg::rupl_state_e state_next;
	logic wr_mailbox, wr_loss, wr_header, trigger, finish;
	logic [1:0] fault_next;
	logic [7:0] rd_mux;

	// ****************************************************************
	// Header decode
	// ****************************************************************
	function automatic logic header_ok(input logic [7:0] hdr);
		header_ok = (hdr != rupl_pkg::HEADER_INVALID);
	endfunction

	function automatic logic [2:0] header_count(input logic [7:0] hdr);
		header_count = {1'b0, hdr[rupl_pkg::LEN_HI:rupl_pkg::LEN_LO]} + 3'h1;
	endfunction

	// ****************************************************************
	// Reset and undervoltage synchronisers
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_b_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_b_reg <= rst_meta_reg;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_sync_b_reg)
	begin
		if (!rst_sync_b_reg)
		begin
			uvlo_meta_reg <= 1'b0;
			uvlo_ok_reg <= 1'b0;
		end
		else
		begin
			uvlo_meta_reg <= rectified_voltage_ok_in;
			uvlo_ok_reg <= uvlo_meta_reg;
		end
	end

	// ****************************************************************
	// Register writes and packet sequencing
	// ****************************************************************
	// Writes are ignored while the rectified voltage is below lockout.
	assign wr_mailbox = reg_wr_in && uvlo_ok_reg &&
		reg_wr_addr_in == rupl_pkg::MAILBOX_ADDR;
	assign wr_loss = reg_wr_in && uvlo_ok_reg &&
		reg_wr_addr_in == rupl_pkg::LOSS_TUNE_ADDR;
	assign wr_header = reg_wr_in && uvlo_ok_reg &&
		reg_wr_addr_in == rupl_pkg::HEADER_ADDR;
	// A start is accepted only while no packet is outstanding.
	assign trigger = wr_mailbox && state_reg == rupl_pkg::RUPL_IDLE &&
		!reg_wr_data_in[rupl_pkg::COMPLETE_BIT];

	always_comb
	begin
		state_next = state_reg;
		finish = 1'b0;
		fault_next = mailbox_reg[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO];
		unique case (state_reg)
			rupl_pkg::RUPL_IDLE:
				if (trigger && !header_ok(header_reg))
				begin
					finish = 1'b1;
					fault_next = rupl_pkg::FAULT_BAD_HEADER;
				end
				else if (trigger)
					state_next = rupl_pkg::RUPL_WAIT_SLOT;
			rupl_pkg::RUPL_WAIT_SLOT:
				if (!tx_present_in)
				begin
					finish = 1'b1;
					fault_next = rupl_pkg::FAULT_NO_TX;
					state_next = rupl_pkg::RUPL_IDLE;
				end
				else if (comm_slot_in)
					state_next = rupl_pkg::RUPL_SENDING;
			rupl_pkg::RUPL_SENDING:
				if (pkt_sent_in)
				begin
					finish = 1'b1;
					fault_next = rupl_pkg::FAULT_NONE;
					state_next = rupl_pkg::RUPL_IDLE;
				end
			default:
				state_next = rupl_pkg::RUPL_IDLE;
		endcase
	end

	// Host owns the low bits; completion and fault are hardware owned,
	// and completion setting wins over a host clear in the same cycle.
	always_comb
	begin
		mailbox_next = mailbox_reg;
		if (wr_mailbox)
			mailbox_next = (mailbox_reg & ~rupl_pkg::MAILBOX_HOST_MASK) |
				(reg_wr_data_in & rupl_pkg::MAILBOX_HOST_MASK);
		if (trigger && !finish)
			mailbox_next[rupl_pkg::COMPLETE_BIT] = 1'b0;
		if (finish)
		begin
			mailbox_next[rupl_pkg::COMPLETE_BIT] = 1'b1;
			mailbox_next[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO] =
				fault_next;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_sync_b_reg)
	begin
		if (!rst_sync_b_reg)
		begin
			mailbox_reg <= rupl_pkg::MAILBOX_RESET;
			loss_tune_reg <= rupl_pkg::LOSS_TUNE_RESET;
			header_reg <= rupl_pkg::HEADER_RESET;
			state_reg <= rupl_pkg::RUPL_IDLE;
		end
		else if (!uvlo_ok_reg)
		begin
			mailbox_reg <= rupl_pkg::MAILBOX_RESET;
			loss_tune_reg <= rupl_pkg::LOSS_TUNE_RESET;
			header_reg <= rupl_pkg::HEADER_RESET;
			state_reg <= rupl_pkg::RUPL_IDLE;
		end
		else
		begin
			mailbox_reg <= mailbox_next;
			state_reg <= state_next;
			if (wr_loss)
				loss_tune_reg <= reg_wr_data_in;
			if (wr_header)
				header_reg <= reg_wr_data_in;
		end
	end

	// ****************************************************************
	// Outputs toward the controller and the host
	// ****************************************************************
	assign rd_mux =
		(reg_rd_addr_in == rupl_pkg::MAILBOX_ADDR) ? mailbox_reg :
		(reg_rd_addr_in == rupl_pkg::LOSS_TUNE_ADDR) ? loss_tune_reg :
		(reg_rd_addr_in == rupl_pkg::HEADER_ADDR) ? header_reg :
		rupl_pkg::UNMAPPED_READ;

	always_ff @(posedge mclk_in or negedge rst_sync_b_reg)
	begin
		if (!rst_sync_b_reg)
		begin
			reg_rd_data_out <= 8'h00;
			pkt_start_out <= 1'b0;
			pkt_header_out <= 8'h00;
			pkt_payload_count_out <= 3'h0;
			align_cep_zero_out <= 1'b0;
		end
		else
		begin
			reg_rd_data_out <= rd_mux;
			pkt_start_out <= uvlo_ok_reg && comm_slot_in && tx_present_in &&
				state_reg == rupl_pkg::RUPL_WAIT_SLOT;
			pkt_header_out <= header_reg;
			pkt_payload_count_out <= header_count(header_reg);
			align_cep_zero_out <= uvlo_ok_reg &&
				mailbox_next[rupl_pkg::ALIGN_BIT];
		end
	end

	rupl_power_adj u_power_adj
	(
		.clk_in(mclk_in),
		.rst_b_in(rst_sync_b_reg),
		.base_power_in(base_power_in),
		.loss_term_in(loss_term_in),
		.res_on_in(loss_tune_reg[rupl_pkg::RES_ON_BIT]),
		.off_on_in(loss_tune_reg[rupl_pkg::OFF_ON_BIT]),
		.off_code_in(loss_tune_reg[rupl_pkg::OFF_HI:rupl_pkg::OFF_LO]),
		.res_code_in(loss_tune_reg[rupl_pkg::RES_HI:rupl_pkg::RES_LO]),
		.power_out(reported_power_out)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_sync_b_reg);

	sequence s_send_done;
		state_reg == rupl_pkg::RUPL_SENDING && pkt_sent_in && uvlo_ok_reg;
	endsequence
	property p_start_clears;
		trigger && header_ok(header_reg) |=>
			!mailbox_reg[rupl_pkg::COMPLETE_BIT] &&
			state_reg == rupl_pkg::RUPL_WAIT_SLOT;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("Start did not clear completion.");

	property p_done_sets;
		s_send_done |=> mailbox_reg[rupl_pkg::COMPLETE_BIT] &&
			mailbox_reg[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO] ==
			rupl_pkg::FAULT_NONE;
	endproperty
	a_done_sets: assert property (p_done_sets)
		else $error("Completion not set after packet sent.");

	property p_bad_header;
		trigger && !header_ok(header_reg) |=>
			mailbox_reg[rupl_pkg::COMPLETE_BIT] &&
			mailbox_reg[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO] ==
			rupl_pkg::FAULT_BAD_HEADER && !pkt_start_out[*2];
	endproperty
	a_bad_header: assert property (p_bad_header)
		else $error("Illegal header was not refused.");

	property p_no_tx;
		state_reg == rupl_pkg::RUPL_WAIT_SLOT && !tx_present_in &&
			uvlo_ok_reg |=> mailbox_reg[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO]
			== rupl_pkg::FAULT_NO_TX && mailbox_reg[rupl_pkg::COMPLETE_BIT];
	endproperty
	a_no_tx: assert property (p_no_tx)
		else $error("Missing transmitter not reported.");

	property p_slot_start;
		state_reg == rupl_pkg::RUPL_WAIT_SLOT && comm_slot_in &&
			tx_present_in && uvlo_ok_reg |=> pkt_start_out &&
			pkt_payload_count_out == header_count($past(header_reg));
	endproperty
	a_slot_start: assert property (p_slot_start)
		else $error("Packet not started in first slot.");

	property p_align;
		uvlo_ok_reg && mailbox_reg[rupl_pkg::ALIGN_BIT] && !wr_mailbox
			|=> align_cep_zero_out;
	endproperty
	a_align: assert property (p_align)
		else $error("Alignment aid not requested.");

	property p_uvlo_reset;
		!uvlo_ok_reg |=> mailbox_reg == rupl_pkg::MAILBOX_RESET &&
			loss_tune_reg == rupl_pkg::LOSS_TUNE_RESET &&
			header_reg == rupl_pkg::HEADER_RESET;
	endproperty
	a_uvlo_reset: assert property (p_uvlo_reset)
		else $error("Registers not reset under lockout.");
	property p_fault_stable;
		mailbox_reg[rupl_pkg::COMPLETE_BIT] &&
			$stable(mailbox_reg[rupl_pkg::COMPLETE_BIT]) |->
			$stable(mailbox_reg[rupl_pkg::FAULT_HI:rupl_pkg::FAULT_LO]) ||
			!$past(uvlo_ok_reg) || $past(trigger);
	endproperty
	a_fault_stable: assert property (p_fault_stable)
		else $error("Fault field changed while complete.");
endmodule

// file: test/rupl_host_model.sv
// Host model: single byte register writes and reads toward the slice.
`timescale 1ns/100ps
module rupl_host_model
(
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	output logic wr_out,
	output logic [7:0] wr_addr_out,
	output logic [7:0] wr_data_out,
	output logic [7:0] rd_addr_out
);
	initial
	begin
		wr_out = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 8'h00;
		rd_addr_out = 8'h00;
	end

	// Released write lines show the inverse, so stale values never pass.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == rupl_pkg::MAILBOX_ADDR)
			v[rupl_pkg::SCALE_SPARE_BIT] = 1'b0;
		wr_out = 1'b1;
		wr_addr_out = a;
		wr_data_out = v;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		wr_addr_out = ~a;
		wr_data_out = ~v;
		// One idle edge keeps back to back writes from retoggling the strobe.
		@(posedge clk_in);
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		rd_addr_out = a;
		@(posedge clk_in);
		#1;
		d = rd_data_in;
	endtask
endmodule

// file: test/tb_rx_user_packet_and_loss_tuning_regs.sv
// Self-checking bench for the user packet and loss tuning slice.
`timescale 1ns/100ps
module tb_rx_user_packet_and_loss_tuning_regs;
	logic mclk_in;
	logic rst_b_in;
	logic volt_ok;
	logic tx_present;
	logic comm_slot;
	logic pkt_sent;
	logic [7:0] base_power;
	logic [7:0] loss_term;
	logic reg_wr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic pkt_start;
	logic [7:0] pkt_header;
	logic [2:0] pay_cnt;
	logic align_cep;
	logic [7:0] rep_power;
	logic [7:0] rd;
	logic [7:0] tune;
	logic [7:0] hdr;
	logic [7:0] pw;
	int n_fail = 0;
	int checks_done = 0;
	int n_start = 0;
	int s0;

	rupl_regs u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.rectified_voltage_ok_in(volt_ok), .reg_wr_in(reg_wr),
		.reg_wr_addr_in(wr_addr), .reg_wr_data_in(wr_data),
		.reg_rd_addr_in(rd_addr), .tx_present_in(tx_present),
		.comm_slot_in(comm_slot), .pkt_sent_in(pkt_sent),
		.base_power_in(base_power), .loss_term_in(loss_term),
		.reg_rd_data_out(rd_data), .pkt_start_out(pkt_start),
		.pkt_header_out(pkt_header), .pkt_payload_count_out(pay_cnt),
		.align_cep_zero_out(align_cep), .reported_power_out(rep_power));

	rupl_host_model u_host (.clk_in(mclk_in), .rd_data_in(rd_data),
		.wr_out(reg_wr), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.rd_addr_out(rd_addr));

	initial
	begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in)
		if (pkt_start === 1'b1)
			n_start <= n_start + 1;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd_reg(a, rd);
		check(rd, exp);
	endtask

	function automatic logic [7:0] mbox(logic c, logic [1:0] f,
		logic [7:0] h);
		return {c, f, h[4:3], 1'b0, h[1:0]};
	endfunction

	// Half scale truncates; unlisted resistance codes stay nominal.
	function automatic logic [7:0] exp_power(logic [7:0] t, logic [7:0] b,
		logic [7:0] l);
		int lo;
		int p;
		lo = l;
		if (t[7])
			case (t[2:0])
				rupl_pkg::RES_X2: lo = l * 2;
				rupl_pkg::RES_X3: lo = l * 3;
				rupl_pkg::RES_X4: lo = l * 4;
				rupl_pkg::RES_HALF: lo = l / 2;
				default: lo = l;
			endcase
		p = b + lo;
		if (t[6])
			p = p + t[5:3] * rupl_pkg::OFFSET_STEP_LSB;
		return (p > 255) ? 8'hFF : 8'(p);
	endfunction

	initial
	begin
		repeat (3000) @(posedge mclk_in);
		n_fail++;
		end_of_test();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		rst_b_in = 1'b0;
		volt_ok = 1'b1;
		tx_present = 1'b1;
		comm_slot = 1'b0;
		pkt_sent = 1'b0;
		base_power = 8'h00;
		loss_term = 8'h00;
		void'($urandom(32'hAE343CD1));
		repeat (16) @(posedge mclk_in);
		#1;
		rst_b_in = 1'b1;
		step(6);
		rd_chk(rupl_pkg::MAILBOX_ADDR, 8'h80);
		rd_chk(rupl_pkg::LOSS_TUNE_ADDR, 8'h00);
		rd_chk(rupl_pkg::HEADER_ADDR, 8'h00);
		rd_chk(8'hE5, rupl_pkg::UNMAPPED_READ);
		for (int i = 0; i < 40; i++)
		begin
			// Pass 38 drives the sum past ten bits to prove saturation.
			tune = (i == 38) ? 8'hFC : 8'($urandom);
			if (i < 8)
				tune = {5'h1F, i[2:0]};
			base_power = (i == 39) ? 8'hFF : 8'($urandom_range(0, 120));
			loss_term = (i == 38) ? 8'hFF : 8'($urandom_range(0, 30));
			u_host.wr_reg(rupl_pkg::LOSS_TUNE_ADDR, tune);
			step(3);
			pw = exp_power(tune, base_power, loss_term);
			check(rep_power, pw);
		end
		rd_chk(rupl_pkg::LOSS_TUNE_ADDR, tune);
		s0 = n_start;
		u_host.wr_reg(rupl_pkg::HEADER_ADDR, 8'h00);
		u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h07);
		pw = mbox(1'b1, rupl_pkg::FAULT_BAD_HEADER, 8'h07);
		rd_chk(8'hE0, pw);
		for (int k = 0; k < 3; k++)
		begin
			hdr = (k == 0) ? 8'hFF : 8'($urandom_range(1, 254));
			u_host.wr_reg(rupl_pkg::HEADER_ADDR, hdr);
			step(1);
			check(pkt_header, hdr);
			check({5'h0, pay_cnt}, {6'h0, hdr[1:0]} + 8'h01);
			u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h10);
			u_host.rd_reg(rupl_pkg::MAILBOX_ADDR, rd);
			check({7'h0, rd[7]}, 8'h00);
			u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h01);
			step(2);
			check(8'(n_start - s0), 8'h00);
			comm_slot = 1'b1;
			step(1);
			comm_slot = 1'b0;
			step(3);
			check(8'(n_start - s0), 8'h01);
			s0 = n_start;
			pkt_sent = 1'b1;
			step(1);
			pkt_sent = 1'b0;
			pw = mbox(1'b1, rupl_pkg::FAULT_NONE, 8'h01);
			rd_chk(8'hE0, pw);
		end
		tx_present = 1'b0;
		u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h00);
		step(2);
		pw = mbox(1'b1, rupl_pkg::FAULT_NO_TX, 8'h00);
		rd_chk(8'hE0, pw);
		comm_slot = 1'b1;
		step(1);
		comm_slot = 1'b0;
		step(2);
		check(8'(n_start - s0), 8'h00);
		tx_present = 1'b1;
		u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h88);
		step(20);
		check({7'h0, align_cep}, 8'h01);
		u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h80);
		step(1);
		check({7'h0, align_cep}, 8'h00);
		u_host.wr_reg(rupl_pkg::MAILBOX_ADDR, 8'h88);
		u_host.wr_reg(rupl_pkg::HEADER_ADDR, 8'h42);
		volt_ok = 1'b0;
		step(4);
		u_host.wr_reg(rupl_pkg::LOSS_TUNE_ADDR, 8'h5A);
		rd_chk(rupl_pkg::MAILBOX_ADDR, 8'h80);
		rd_chk(rupl_pkg::LOSS_TUNE_ADDR, 8'h00);
		rd_chk(rupl_pkg::HEADER_ADDR, 8'h00);
		check({7'h0, align_cep}, 8'h00);
		volt_ok = 1'b1;
		step(4);
		u_host.wr_reg(rupl_pkg::LOSS_TUNE_ADDR, 8'h5A);
		rd_chk(rupl_pkg::LOSS_TUNE_ADDR, 8'h5A);
		end_of_test();
	end
endmodule
